// File: shared/mcs_pkg.sv
// Summary of operation
// - Hold an 8-bit store address; upper two bits pick the card; tie card selects high.
// - Decode the low six address bits into twelve select lines, three groups of four.
// - Low, middle, high base-four digits pick gate, row, column: one of 64 words.
// - Drive the selected word line low; with none selected all lines read one.
// - T is the OR of the 4x4 condition matrix gated by row and column selects.
// - Two J-K flags update only on the flag load strobe; J from the flag set inputs, K from microcode.
// - U is the OR of column-gated flag tests and row-gated external U conditions.
// - JUMP and COUNT come from branch-true, branch-false, select fields, T, U and done.
// - Branch-true picks the adder operand: zero, dispatch address or save register.
// - The adder sums the 8-bit offset field and the operand to form the jump target.
// - Each clock the counter holds, increments, or loads one of three adder results.
// - Clear forces the program counter to zero.
// - COUNT on a clock advances the program counter by one.
// - JUMP on a clock loads the adder output into the program counter.
// - The low six counter bits are decoded two bits at a time into active-low select lines.
// - The save register captures the counter while the save strobe is high.
package mcs_pkg;

	localparam int          AXI_ADDR_W   = 8;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_JC_TABLE = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;
	localparam int          CTRL_CLR_BIT = 0;
	localparam int          ST_PC_LSB    = 0;
	localparam int          ST_SAVE_LSB  = 8;
	localparam int          ST_FLAG1_BIT = 16;
	localparam int          ST_FLAG2_BIT = 17;
	localparam int          ST_T_BIT     = 18;
	localparam int          ST_U_BIT     = 19;
	localparam int          ST_JUMP_BIT  = 20;
	localparam int          ST_COUNT_BIT = 21;
	// Entry {jump,count} per index {test,field}: false path 00 count, 01 hold, 1x jump
	localparam logic [15:0] JC_TABLE_RST = 16'hAAA1;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [7:0]  PC_RST       = 8'h00;
	localparam logic [7:0]  ZERO_OPERAND = 8'hFF;

	// Register select codes shared by write and read decode
	typedef enum logic [1:0] {SEL_CTRL, SEL_TABLE, SEL_STATUS, SEL_NONE} mcs_rsel_type;

	// One microinstruction's sequencing fields
	typedef struct packed {
		logic [7:0] addr_offset;
		logic [1:0] branch_true_field;
		logic [1:0] branch_false_field;
		logic [1:0] select_field;
		logic       test_col_sel_a;
		logic       test_col_sel_b;
		logic       test_col_sel_c;
		logic       test_col_sel_d;
		logic       test_row_sel_a;
		logic       test_row_sel_b;
		logic       test_row_sel_c;
		logic       test_row_sel_d;
		logic       flag1_clear_in;
		logic       flag2_clear_in;
		logic       save_strobe;
	} mcs_uinst_type;

	// Condition sources from the rest of the processor
	typedef struct packed {
		logic [15:0] t_condition_input;
		logic [3:0]  u_condition_input;
		logic        flag1_set_in;
		logic        flag2_set_in;
		logic        flag_load_strobe;
		logic        done;
		logic [7:0]  dispatch_address;
	} mcs_cond_type;

	// Entire state of the sequencer
	typedef struct packed {
		logic [7:0]            pc;
		logic [7:0]            save;
		logic                  flag1;
		logic                  flag2;
		logic [15:0]           jc_table;
		logic                  soft_clr;
		logic                  aw_held;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} mcs_state_type;

endpackage : mcs_pkg

// File: core/mcs_word_decoder.sv
`timescale 1ns/1ps
module mcs_word_decoder
(
	input  wire logic [5:0]  addr_low_i,
	input  wire logic        card_en_i,
	output logic      [11:0] word_addr_select_n_o,
	output logic      [63:0] word_line_n_o
);
	import mcs_pkg::*;

	// One-of-four decode, used for all three digits
	function automatic logic [3:0] one_of_four(input logic [1:0] digit);
		one_of_four = 4'h1 << digit;
	endfunction : one_of_four

	logic [11:0] sel_hi;

	// Three base-four digits, each to four select lines
	always_comb
	begin
		sel_hi[3:0]  = one_of_four(addr_low_i[1:0]);
		sel_hi[7:4]  = one_of_four(addr_low_i[3:2]);
		sel_hi[11:8] = one_of_four(addr_low_i[5:4]);
	end

	assign word_addr_select_n_o = ~sel_hi;

	// Gate = low digit, row = middle digit, column = high digit
	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++)
		begin : g_word
			assign word_line_n_o[gi] = ~(card_en_i & sel_hi[gi % 4]
				& sel_hi[4 + (gi / 4) % 4] & sel_hi[8 + gi / 16]);
		end
	endgenerate

endmodule : mcs_word_decoder

// File: core/mcs_sequencer.sv
`timescale 1ns/1ps
module mcs_sequencer
(
	input  wire logic                           clock_i,
	input  wire logic                           srst_i,
	// Processor master clear, same clock domain
	input  wire logic                           clear_i,
	input  wire mcs_pkg::mcs_uinst_type         uinst_i,
	input  wire mcs_pkg::mcs_cond_type          cond_i,
	// Card select inputs; a lone card has both tied high
	input  wire logic [1:0]                     card_sel_i,
	output logic      [7:0]                     pc_o,
	output logic      [1:0]                     card_addr_o,
	output logic      [11:0]                    word_addr_select_n_o,
	output logic      [63:0]                    word_line_n_o,
	output logic                                t_o,
	output logic                                t_n_o,
	output logic                                u_o,
	output logic                                u_n_o,
	output logic                                flag1_o,
	output logic                                flag2_o,
	// AXI4-Lite slave
	input  wire logic [mcs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic      [1:0]                     s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [mcs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic      [31:0]                    s_axi_rdata,
	output logic      [1:0]                     s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready
);
	import mcs_pkg::*;

	// Word-aligned decode shared by the write and read paths
	function automatic mcs_rsel_type reg_decode(input logic [AXI_ADDR_W-1:0] addr);
		logic [AXI_ADDR_W-1:0] word;
		word = {addr[AXI_ADDR_W-1:2], 2'b00};
		case (word)
			OFS_CTRL:     reg_decode = SEL_CTRL;
			OFS_JC_TABLE: reg_decode = SEL_TABLE;
			OFS_STATUS:   reg_decode = SEL_STATUS;
			default:      reg_decode = SEL_NONE;
		endcase
	endfunction : reg_decode

	// Branch condition chosen by the select field
	function automatic logic pick_test(input logic [1:0] sel, input logic t,
		input logic u, input logic d);
		case (sel)
			2'h0:    pick_test = t;
			2'h1:    pick_test = u;
			2'h2:    pick_test = d;
			default: pick_test = 1'b1;
		endcase
	endfunction : pick_test

	mcs_state_type state_ff;
	mcs_state_type nxt_state;

	logic [3:0]  col_sel;
	logic [3:0]  row_sel;
	logic        t_res;
	logic        u_res;
	logic [3:0]  flag_tests;
	logic        test_res;
	logic [1:0]  field;
	logic [2:0]  jc_index;
	logic        jump;
	logic        count;
	logic [7:0]  operand;
	logic        carry_in;
	logic [8:0]  sum_full;
	logic [7:0]  jump_target;
	logic        card_en;
	logic [31:0] status_word;

	// Column and row selects as vectors; index 0 is the a line
	assign col_sel = {uinst_i.test_col_sel_d, uinst_i.test_col_sel_c,
		uinst_i.test_col_sel_b, uinst_i.test_col_sel_a};
	assign row_sel = {uinst_i.test_row_sel_d, uinst_i.test_row_sel_c,
		uinst_i.test_row_sel_b, uinst_i.test_row_sel_a};

	// T matrix: condition r*4+c enabled where row r and column c meet
	always_comb
	begin
		t_res = 1'b0;
		for (int r = 0; r < 4; r++)
		begin
			for (int c = 0; c < 4; c++)
			begin
				t_res = t_res | (cond_i.t_condition_input[r * 4 + c]
					& row_sel[r] & col_sel[c]);
			end
		end
	end

	// Flag true and complement tests share the T column selects
	assign flag_tests = {~state_ff.flag2, state_ff.flag2, ~state_ff.flag1, state_ff.flag1};
	assign u_res = |(flag_tests & col_sel)
		| |(cond_i.u_condition_input & row_sel);

	// Complemented tests come from swapping true and false fields in microcode
	always_comb
	begin
		test_res = pick_test(uinst_i.select_field, t_res, u_res, cond_i.done);
		field    = test_res ? uinst_i.branch_true_field : uinst_i.branch_false_field;
		jc_index = {test_res, field};
		jump     = state_ff.jc_table[2 * jc_index + 1];
		count    = state_ff.jc_table[2 * jc_index];
	end

	// Zero operand is all ones plus carry, as the original adder did it
	always_comb
	begin
		if (!uinst_i.branch_true_field[1])
		begin
			operand  = ZERO_OPERAND;
			carry_in = 1'b1;
		end
		else if (!uinst_i.branch_true_field[0])
		begin
			operand  = cond_i.dispatch_address;
			carry_in = 1'b0;
		end
		else
		begin
			operand  = state_ff.save;
			carry_in = 1'b0;
		end
		sum_full    = {1'b0, uinst_i.addr_offset} + {1'b0, operand} + {8'h00, carry_in};
		jump_target = sum_full[7:0];
	end

	// Status word: counter, save register, flags, tests and commands
	always_comb
	begin
		status_word                           = 32'h0000_0000;
		status_word[ST_PC_LSB +: 8]           = state_ff.pc;
		status_word[ST_SAVE_LSB +: 8]         = state_ff.save;
		status_word[ST_FLAG1_BIT]             = state_ff.flag1;
		status_word[ST_FLAG2_BIT]             = state_ff.flag2;
		status_word[ST_T_BIT]                 = t_res;
		status_word[ST_U_BIT]                 = u_res;
		status_word[ST_JUMP_BIT]              = jump;
		status_word[ST_COUNT_BIT]             = count;
	end

	// Next-state logic for sequencer and bus slave
	always_comb
	begin
		nxt_state          = state_ff;
		nxt_state.soft_clr = 1'b0;

		// Program counter: clear, then jump over count, else hold
		if (clear_i || state_ff.soft_clr)
		begin
			nxt_state.pc = PC_RST;
		end
		else if (jump)
		begin
			nxt_state.pc = jump_target;
		end
		else if (count)
		begin
			nxt_state.pc = state_ff.pc + 8'h01;
		end // Neither command: hold

		// Save captures the present counter for one-level return
		if (uinst_i.save_strobe)
		begin
			nxt_state.save = state_ff.pc;
		end

		// J-K flags move only on the load strobe; both high toggles
		if (cond_i.flag_load_strobe)
		begin
			case ({cond_i.flag1_set_in, uinst_i.flag1_clear_in})
				2'b10:   nxt_state.flag1 = 1'b1;
				2'b01:   nxt_state.flag1 = 1'b0;
				2'b11:   nxt_state.flag1 = ~state_ff.flag1;
				default: nxt_state.flag1 = state_ff.flag1;
			endcase
			case ({cond_i.flag2_set_in, uinst_i.flag2_clear_in})
				2'b10:   nxt_state.flag2 = 1'b1;
				2'b01:   nxt_state.flag2 = 1'b0;
				2'b11:   nxt_state.flag2 = ~state_ff.flag2;
				default: nxt_state.flag2 = state_ff.flag2;
			endcase
		end

		// Response handshakes retire here; a new one can follow from the next cycle
		if (state_ff.bvalid && s_axi_bready)
		begin
			nxt_state.bvalid = 1'b0;
		end
		if (state_ff.rvalid && s_axi_rready)
		begin
			nxt_state.rvalid = 1'b0;
		end

		// Address and data are latched independently, in either order
		if (s_axi_awvalid && !state_ff.aw_held)
		begin
			nxt_state.aw_held = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_ff.w_held)
		begin
			nxt_state.w_held = 1'b1;
			nxt_state.w_data = s_axi_wdata;
			nxt_state.w_strb = s_axi_wstrb;
		end

		// Commit once both halves are here and the last response is gone
		if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid)
		begin
			nxt_state.aw_held = 1'b0;
			nxt_state.w_held  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			nxt_state.bresp   = RESP_OKAY;
			case (reg_decode(state_ff.aw_addr))
				SEL_CTRL:
				begin
					if (state_ff.w_strb[0])
					begin
						nxt_state.soft_clr = state_ff.w_data[CTRL_CLR_BIT];
					end
				end
				SEL_TABLE:
				begin
					if (state_ff.w_strb[0])
					begin
						nxt_state.jc_table[7:0] = state_ff.w_data[7:0];
					end
					if (state_ff.w_strb[1])
					begin
						nxt_state.jc_table[15:8] = state_ff.w_data[15:8];
					end
				end
				SEL_STATUS:
				begin
					// Read-only: write accepted and dropped
					nxt_state.bresp = RESP_OKAY;
				end
				default:
				begin
					nxt_state.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Read: one outstanding, data captured at the address handshake
		if (s_axi_arvalid && !state_ff.rvalid)
		begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp  = RESP_OKAY;
			case (reg_decode(s_axi_araddr))
				SEL_CTRL:   nxt_state.rdata = 32'h0000_0000;
				SEL_TABLE:  nxt_state.rdata = {16'h0000, state_ff.jc_table};
				SEL_STATUS: nxt_state.rdata = status_word;
				default:
				begin
					nxt_state.rdata = 32'h0000_0000;
					nxt_state.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	// Single state register; sync reset leaves a known sequencer and idle bus
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_ff          <= '0;
			state_ff.pc       <= PC_RST;
			state_ff.jc_table <= JC_TABLE_RST;
			state_ff.bresp    <= RESP_OKAY;
			state_ff.rresp    <= RESP_OKAY;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// Card enabled only when both select inputs are high
	assign card_en     = &card_sel_i;
	assign card_addr_o = state_ff.pc[7:6];
	assign pc_o        = state_ff.pc;

	// Word decoder works from the registered counter, so lines are glitch-limited
	mcs_word_decoder u_word_decoder
	(
		.addr_low_i           (state_ff.pc[5:0]),
		.card_en_i            (card_en),
		.word_addr_select_n_o (word_addr_select_n_o),
		.word_line_n_o        (word_line_n_o)
	);

	// Test results and flags for the rest of the processor
	assign t_o     = t_res;
	assign t_n_o   = ~t_res;
	assign u_o     = u_res;
	assign u_n_o   = ~u_res;
	assign flag1_o = state_ff.flag1;
	assign flag2_o = state_ff.flag2;

	// Bus handshakes
	assign s_axi_awready = !state_ff.aw_held;
	assign s_axi_wready  = !state_ff.w_held;
	assign s_axi_bvalid  = state_ff.bvalid;
	assign s_axi_bresp   = state_ff.bresp;
	assign s_axi_arready = !state_ff.rvalid;
	assign s_axi_rvalid  = state_ff.rvalid;
	assign s_axi_rdata   = state_ff.rdata;
	assign s_axi_rresp   = state_ff.rresp;

endmodule : mcs_sequencer

// File: verif/mcs_chk.sv
`timescale 1ns/1ps
module mcs_chk
(
	input wire logic                   clock_i,
	input wire logic                   srst_i,
	input wire logic                   clear_i,
	input wire mcs_pkg::mcs_uinst_type uinst_i,
	input wire mcs_pkg::mcs_cond_type  cond_i,
	input wire logic [1:0]             card_sel_i,
	input wire logic [7:0]             pc_o,
	input wire logic [1:0]             card_addr_o,
	input wire logic [11:0]            word_addr_select_n_o,
	input wire logic [63:0]            word_line_n_o,
	input wire logic                   t_o,
	input wire logic                   t_n_o,
	input wire logic                   u_o,
	input wire logic                   u_n_o,
	input wire logic                   flag1_o,
	input wire logic                   flag2_o
);
	import mcs_pkg::*;
	logic [3:0]  row, col;
	logic [15:0] t_mask;
	logic [7:0]  save_ff;
	// Select lines as vectors, index 0 is the a line
	assign row = {uinst_i.test_row_sel_d, uinst_i.test_row_sel_c,
		uinst_i.test_row_sel_b, uinst_i.test_row_sel_a};
	assign col = {uinst_i.test_col_sel_d, uinst_i.test_col_sel_c,
		uinst_i.test_col_sel_b, uinst_i.test_col_sel_a};
	// A cell is live only where its row and its column are both selected
	always_comb
		for (int i = 0; i < 16; i++)
			t_mask[i] = row[i / 4] & col[i % 4];
	// Shadow of the return address, which the design keeps internal
	always_ff @(posedge clock_i)
		save_ff <= srst_i ? 8'h00 : (uinst_i.save_strobe ? pc_o : save_ff);
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	a_clear_zero: assert property (clear_i |=> pc_o == 8'h00)
		else $error("pc not zero after clear");
	a_word_line: assert property (&card_sel_i |-> word_line_n_o == ~(64'h1 << pc_o[5:0]))
		else $error("wrong word line");
	a_card_idle: assert property (!(&card_sel_i) |-> &word_line_n_o)
		else $error("word line low while card off");
	// Card address and the U complement are exported but read by nothing in the bench
	a_card_addr: assert property (card_addr_o == pc_o[7:6] && u_n_o == !u_o)
		else $error("bad card address or U complement");
	a_digit_sel: assert property (word_addr_select_n_o ==
		~{4'h1 << pc_o[5:4], 4'h1 << pc_o[3:2], 4'h1 << pc_o[1:0]}) else $error("bad select");
	a_t_matrix: assert property (t_o == |(cond_i.t_condition_input & t_mask) && t_n_o == !t_o)
		else $error("bad T test");
	a_u_tests: assert property (u_o ==
		|({~flag2_o, flag2_o, ~flag1_o, flag1_o} & col | cond_i.u_condition_input & row))
		else $error("bad U test");
	a_flag_hold: assert property (!cond_i.flag_load_strobe && !clear_i |=>
		$stable({flag1_o, flag2_o})) else $error("flags moved without strobe");
	a_count_inc: assert property (!clear_i && uinst_i.select_field == 2'h0 && !t_o &&
		uinst_i.branch_false_field == 2'h0 |=> pc_o == $past(pc_o) + 8'h01)
		else $error("count did not advance");
	a_hold_pc: assert property (!clear_i && uinst_i.select_field == 2'h0 && !t_o &&
		uinst_i.branch_false_field == 2'h1 |=> $stable(pc_o)) else $error("pc not held");
	a_jump_offset: assert property (!clear_i && uinst_i.select_field == 2'h3 &&
		!uinst_i.branch_true_field[1] |=> pc_o == $past(uinst_i.addr_offset))
		else $error("jump to offset wrong");
	a_jump_disp: assert property (!clear_i && uinst_i.select_field == 2'h3 &&
		uinst_i.branch_true_field == 2'h2 |=>
		pc_o == $past(uinst_i.addr_offset) + $past(cond_i.dispatch_address))
		else $error("dispatch jump wrong");
	a_save_ret: assert property (!clear_i && uinst_i.select_field == 2'h3 &&
		uinst_i.branch_true_field == 2'h3 |=> pc_o == $past(uinst_i.addr_offset) + $past(save_ff))
		else $error("return jump wrong");
endmodule : mcs_chk
bind mcs_sequencer mcs_chk chk (.clock_i, .srst_i, .clear_i, .uinst_i, .cond_i, .card_sel_i,
	.pc_o, .card_addr_o, .word_addr_select_n_o, .word_line_n_o, .t_o, .t_n_o, .u_o, .u_n_o,
	.flag1_o, .flag2_o);

// File: verif/mcs_rom_model.sv
`timescale 1ns/1ps
module mcs_rom_model
(
	input  wire logic                   clock_i,
	input  wire logic [63:0]            word_line_n_i,
	output mcs_pkg::mcs_uinst_type      uinst_o
);
	import mcs_pkg::*;
	mcs_uinst_type mem [64];
	mcs_uinst_type last_ff;
	// A low line reads its word; with all lines high nothing is selected and the
	// outputs float, shown as a pattern that flips every cycle
	always_comb
	begin
		uinst_o = ~last_ff;
		for (int i = 0; i < 64; i++)
			if (!word_line_n_i[i])
				uinst_o = mem[i];
	end
	always_ff @(posedge clock_i)
		last_ff <= uinst_o;
endmodule : mcs_rom_model

// File: verif/mcs_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module mcs_sequencer_bench;
	import mcs_pkg::*;
	logic          clock_i = 0, srst_i = 1, clear_i = 0, use_rom = 0;
	logic [1:0]    card_sel_i = 2'h3, s_axi_bresp, s_axi_rresp;
	mcs_uinst_type uinst_d, rom_u, uinst, idle;
	mcs_cond_type  cond = '0;
	logic [7:0]    pc_o, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, epc = 8'h00, esv = 8'h00, o;
	logic          s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic          s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic          s_axi_arready, s_axi_rvalid;
	logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]    s_axi_wstrb = 4'hF;
	logic [63:0]   word_line_n_o;
	logic [33:0]   exp_q [$];
	int            error_cnt = 0, cmp_count = 0, i;
	event          pc_ev;
	assign uinst = use_rom ? rom_u : uinst_d;
	always #5 clock_i = ~clock_i;
	mcs_sequencer uut (.clock_i, .srst_i, .clear_i, .uinst_i(uinst), .cond_i(cond), .card_sel_i,
		.pc_o, .card_addr_o(), .word_addr_select_n_o(), .word_line_n_o, .t_o(), .t_n_o(),
		.u_o(), .u_n_o(), .flag1_o(), .flag2_o(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	mcs_rom_model rom (.clock_i, .word_line_n_i(word_line_n_o), .uinst_o(rom_u));
	function automatic mcs_uinst_type mk(input logic [1:0] s, t, f, input logic [7:0] of,
		input logic [3:0] r = 4'h0, c = 4'h0, input logic [2:0] x = 3'h0);
		return {of, t, f, s, c[0], c[1], c[2], c[3], r[0], r[1], r[2], r[3], x};
	endfunction : mk
	// Status word while T, U, jump and count are all low
	function automatic logic [33:0] st(input logic [1:0] fl);
		return {RESP_OKAY, 14'h0, fl, esv, epc};
	endfunction : st
	task conclude();
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	// Oldest note against what appeared; an empty queue never matches
	task chk(input logic [33:0] g);
		logic [33:0] e;
		e = exp_q.size() ? exp_q.pop_front() : 34'h3FFFFFFFF;
		`CHK(g, e)
	endtask : chk
	always @(posedge clock_i)
	begin
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h0});
	end
	always @(pc_ev)
	begin
		#1;
		chk({26'h0, pc_o});
	end
	// One bus cycle; each valid is held until its own ready is seen, each response ready until its valid
	task axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
		int n;
		@(posedge clock_i);
		exp_q.push_back(e);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		n = 0;
		do
		begin
			@(posedge clock_i);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b0;
		end
		while ((s_axi_bready || s_axi_rready) && n < 40);
		if (n >= 40)
		begin
			error_cnt++;
			conclude();
		end
	endtask : axi
	// One microinstruction for one clock, then back to the holding word
	task step(input mcs_uinst_type u, input logic c, input logic [7:0] e);
		@(posedge clock_i);
		uinst_d <= u;
		clear_i <= c;
		exp_q.push_back({26'h0, e});
		@(posedge clock_i);
		uinst_d <= idle;
		clear_i <= 1'b0;
		->pc_ev;
		epc = e;
	endtask : step
	task fl(input mcs_uinst_type u);
		@(posedge clock_i);
		cond.flag_load_strobe <= 1'b1;
		uinst_d <= u;
		@(posedge clock_i);
		cond.flag_load_strobe <= 1'b0;
		uinst_d <= idle;
	endtask : fl
	initial
	begin
		void'($urandom(32'hC62372E9));
		idle = mk(2'h2, 2'h0, 2'h1, 8'h00);
		uinst_d = idle;
		for (i = 0; i < 64; i++)
			rom.mem[i] = 25'($urandom);
		repeat (4) @(posedge clock_i);
		srst_i <= 1'b0;
		axi(0, OFS_JC_TABLE, 0, {RESP_OKAY, 16'h0, JC_TABLE_RST});
		o = 8'($urandom);
		step(mk(2'h3, 2'h0, 2'h0, o), 0, o);
		step(mk(2'h3, 2'h1, 2'h0, 8'hFF), 0, 8'hFF);
		step(mk(2'h0, 2'h0, 2'h0, 8'h12), 0, 8'h00);
		step(mk(2'h0, 2'h0, 2'h1, 8'h55), 0, epc);
		// Every matrix cell once selected, once beside a wrong column
		for (i = 0; i < 32; i++)
		begin
			o = 8'($urandom);
			cond.t_condition_input <= 16'h1 << (i % 16);
			step(mk(2'h0, 2'h0, 2'h1, o, 4'h1 << (i % 16 / 4), 4'h1 << ((i % 16 + i / 16) % 4)),
				0, i < 16 ? o : epc);
		end
		for (i = 0; i < 8; i++)
		begin
			o = 8'($urandom);
			cond.u_condition_input <= 4'h1 << (i % 4);
			step(mk(2'h1, 2'h0, 2'h1, o, i > 3 ? 4'h1 << (i % 4) : 4'h0, i < 4 ? 4'h1 << i : 4'h0),
				0, (i > 3 || i % 2) ? o : epc);
		end
		cond <= '0;
		step(mk(2'h3, 2'h0, 2'h0, 8'hA5), 1, 8'h00);
		step(mk(2'h3, 2'h0, 2'h0, 8'h3C), 0, 8'h3C);
		axi(1, OFS_CTRL, 32'h1, {RESP_OKAY, 32'h0});
		epc = 8'h00;
		axi(0, OFS_CTRL, 0, {RESP_OKAY, 32'h0});
		axi(0, OFS_STATUS, 0, st(2'h0));
		axi(1, 8'h0C, 32'h1234, {RESP_SLVERR, 32'h0});
		axi(0, 8'h0C, 0, {RESP_SLVERR, 32'h0});
		axi(1, OFS_STATUS, 32'hFFFFFFFF, {RESP_OKAY, 32'h0});
		axi(0, OFS_STATUS, 0, st(2'h0));
		axi(1, OFS_JC_TABLE, 32'hAA91, {RESP_OKAY, 32'h0});
		axi(0, OFS_JC_TABLE, 0, {RESP_OKAY, 32'hAA91});
		step(mk(2'h0, 2'h0, 2'h2, 8'h77), 0, epc + 8'h01);
		axi(1, OFS_JC_TABLE, {16'h0, JC_TABLE_RST}, {RESP_OKAY, 32'h0});
		// Set inputs alone change nothing until the load strobe comes
		cond.flag1_set_in <= 1'b1;
		cond.flag2_set_in <= 1'b1;
		axi(0, OFS_STATUS, 0, st(2'h0));
		fl(idle);
		axi(0, OFS_STATUS, 0, st(2'h3));
		fl(mk(2'h2, 2'h0, 2'h1, 8'h00, 4'h0, 4'h0, 3'h4));
		axi(0, OFS_STATUS, 0, st(2'h2));
		cond.flag1_set_in <= 1'b0;
		cond.flag2_set_in <= 1'b0;
		fl(mk(2'h2, 2'h0, 2'h1, 8'h00, 4'h0, 4'h0, 3'h6));
		axi(0, OFS_STATUS, 0, st(2'h0));
		// Done as the tested condition; the holding word jumps to zero first, harmlessly
		cond.done <= 1'b1;
		step(mk(2'h2, 2'h0, 2'h1, 8'h6B), 0, 8'h6B);
		cond.done <= 1'b0;
		o = 8'($urandom);
		cond.dispatch_address <= 8'($urandom);
		@(posedge clock_i);
		step(mk(2'h3, 2'h2, 2'h0, o), 0, o + cond.dispatch_address);
		step(mk(2'h2, 2'h0, 2'h1, 8'h00, 4'h0, 4'h0, 3'h1), 0, epc);
		esv = epc;
		step(mk(2'h3, 2'h3, 2'h0, 8'hF0), 0, 8'hF0 + esv);
		axi(0, OFS_STATUS, 0, st(2'h0));
		card_sel_i <= 2'h1;
		repeat (3) @(posedge clock_i);
		card_sel_i <= 2'h3;
		// Free run from the store model with random conditions
		use_rom <= 1'b1;
		repeat (400)
		begin
			@(posedge clock_i);
			cond <= $urandom;
			card_sel_i <= ($urandom % 8 == 0) ? 2'($urandom) : 2'h3;
		end
		conclude();
	end
endmodule : mcs_sequencer_bench
